// ==== logic/emb_regs.svh ====
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH

// Pin widths
`define EMB_ADDR_W        21
`define EMB_LOW_ADDR_W    16
`define EMB_DATA_W        16
`define EMB_NUM_CS        4
`define EMB_MODE_W        3

// Boot mode straps share the top data pins
`define EMB_STRAP_LSB     13
`define EMB_STRAP_MSB     15

// System integration control word and its mode field
`define EMB_SIC_CTRL_ADDR 21'h1fff08
`define EMB_SIC_MODE_LSB  12
`define EMB_SIC_MODE_MSB  14

// Default read and write strobe lengths in core clocks
`define EMB_RD_STROBE_CYC 2
`define EMB_WR_STROBE_CYC 2
`define EMB_CNT_W         4

// Strobe pin levels, idle and active
`define EMB_STROBE_OFF    1'h1
`define EMB_STROBE_ON     1'h0

`endif

// ==== logic/emb_pkg.sv ====
package emb_pkg;

  typedef enum logic [2:0]
  {
    EMB_IDLE,
    EMB_RD_STROBE,
    EMB_WR_SETUP,
    EMB_WR_STROBE,
    EMB_WR_HOLD
  } emb_state_t;

  typedef logic [2:0] emb_boot_mode_t;

endpackage

// ==== logic/emb_top.sv ====
`timescale 1ns/1ps
`include "emb_regs.svh"

module emb_top
  import emb_pkg::*;
#(
  parameter int RD_STROBE_CYC = `EMB_RD_STROBE_CYC,
  parameter int WR_STROBE_CYC = `EMB_WR_STROBE_CYC
)
(
  input  wire logic                               ref_clk_i,
  input  wire logic                               nrst_i,
  input  wire logic                               por_n_i,
  input  wire logic                               ext_rst_n_i,
  input  wire logic                               sw_rst_i,
  input  wire logic                               watchdog_reset_source_i,
  input  wire logic                               req_valid_i,
  input  wire logic                               req_write_i,
  input  wire logic [`EMB_ADDR_W-1:0]             req_addr_i,
  input  wire logic [`EMB_DATA_W-1:0]             req_wdata_i,
  input  wire logic [`EMB_NUM_CS-1:0]             cs_enable_i,
  input  wire logic [`EMB_NUM_CS*`EMB_ADDR_W-1:0] cs_base_i,
  input  wire logic [`EMB_NUM_CS*`EMB_ADDR_W-1:0] cs_mask_i,
  output logic                                    busy_o,
  output logic                                    rd_valid_o,
  output logic [`EMB_DATA_W-1:0]                  rd_data_o,
  output logic [`EMB_DATA_W-1:0]                  system_integration_control_o,
  output logic [`EMB_ADDR_W-1:0]                  addr_o,
  input  wire logic [`EMB_DATA_W-1:0]             data_i,
  output logic [`EMB_DATA_W-1:0]                  data_o,
  output logic [`EMB_DATA_W-1:0]                  data_oe_o,
  output logic                                    rd_n_o,
  output logic                                    wr_n_o,
  output logic [`EMB_NUM_CS-1:0]                  chip_select_n_o
);

  localparam logic [`EMB_CNT_W-1:0] RD_LAST =
    `EMB_CNT_W'(RD_STROBE_CYC - 1);
  localparam logic [`EMB_CNT_W-1:0] WR_LAST =
    `EMB_CNT_W'(WR_STROBE_CYC - 1);

  function automatic logic emb_cs_hit
  (
    input logic [`EMB_ADDR_W-1:0] addr,
    input logic [`EMB_ADDR_W-1:0] base,
    input logic [`EMB_ADDR_W-1:0] mask
  );
    emb_cs_hit = ((addr ^ base) & mask) == '0;
  endfunction

  // Any of these resets the bus sequencer; only two of them touch the mode
  logic bus_rst;
  logic strap_rst;

  assign strap_rst = !por_n_i || !ext_rst_n_i;
  assign bus_rst   = !nrst_i || strap_rst || sw_rst_i ||
                     watchdog_reset_source_i;

  // Boot mode strap capture
  emb_boot_mode_t mode_q;
  emb_boot_mode_t mode_d;

  always_comb
  begin
    mode_d = mode_q;
    // Tracked every cycle of reset, so the last sample before release stays
    if (strap_rst)
    begin
      mode_d = data_i[`EMB_STRAP_MSB:`EMB_STRAP_LSB];
    end
  end

  // No reset term: a software or watchdog reset must not disturb it
  always_ff @(posedge ref_clk_i)
  begin
    mode_q <= mode_d;
  end

  always_comb
  begin
    system_integration_control_o = '0;
    system_integration_control_o[`EMB_SIC_MODE_MSB:`EMB_SIC_MODE_LSB] =
      mode_q;
  end

  // Chip select decode of the incoming request
  logic [`EMB_NUM_CS-1:0] cs_hit;

  genvar gi;
  generate
    for (gi = 0; gi < `EMB_NUM_CS; gi++)
    begin : g_cs
      assign cs_hit[gi] = cs_enable_i[gi] &&
        emb_cs_hit(req_addr_i,
                   cs_base_i[gi*`EMB_ADDR_W +: `EMB_ADDR_W],
                   cs_mask_i[gi*`EMB_ADDR_W +: `EMB_ADDR_W]);
    end
  endgenerate

  // Bus sequencer
  emb_state_t             state_q;
  emb_state_t             state_d;
  logic [`EMB_CNT_W-1:0]  cnt_q;
  logic [`EMB_CNT_W-1:0]  cnt_d;
  logic [`EMB_ADDR_W-1:0] addr_q;
  logic [`EMB_ADDR_W-1:0] addr_d;
  logic [`EMB_DATA_W-1:0] wdata_q;
  logic [`EMB_DATA_W-1:0] wdata_d;
  logic [`EMB_DATA_W-1:0] oe_q;
  logic [`EMB_DATA_W-1:0] oe_d;
  logic [`EMB_DATA_W-1:0] rdata_q;
  logic [`EMB_DATA_W-1:0] rdata_d;
  logic [`EMB_NUM_CS-1:0] cs_n_q;
  logic [`EMB_NUM_CS-1:0] cs_n_d;
  logic                   rd_n_q;
  logic                   rd_n_d;
  logic                   wr_n_q;
  logic                   wr_n_d;
  logic                   rvalid_q;
  logic                   rvalid_d;
  logic                   busy_q;
  logic                   busy_d;

  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    oe_d     = oe_q;
    rdata_d  = rdata_q;
    cs_n_d   = cs_n_q;
    rd_n_d   = rd_n_q;
    wr_n_d   = wr_n_q;
    rvalid_d = 1'b0;
    case (state_q)
      EMB_IDLE:
      begin
        oe_d   = '0;
        cs_n_d = '1;
        rd_n_d = `EMB_STROBE_OFF;
        wr_n_d = `EMB_STROBE_OFF;
        cnt_d  = '0;
        if (req_valid_i)
        begin
          addr_d = req_addr_i;
          cs_n_d = ~cs_hit;
          if (req_write_i)
          begin
            // Data leads the strobe by one clock so the memory sees it settled
            wdata_d = req_wdata_i;
            oe_d    = '1;
            state_d = EMB_WR_SETUP;
          end
          else
          begin
            oe_d    = '0;
            rd_n_d  = `EMB_STROBE_ON;
            state_d = EMB_RD_STROBE;
          end
        end
      end
      EMB_RD_STROBE:
      begin
        if (cnt_q == RD_LAST)
        begin
          // Sampled on the same edge that lifts the strobe
          rdata_d  = data_i;
          rd_n_d   = `EMB_STROBE_OFF;
          rvalid_d = 1'b1;
          cs_n_d   = '1;
          state_d  = EMB_IDLE;
        end
        else
        begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      EMB_WR_SETUP:
      begin
        wr_n_d  = `EMB_STROBE_ON;
        state_d = EMB_WR_STROBE;
      end
      EMB_WR_STROBE:
      begin
        // Address and data stay put until after the rising strobe
        if (cnt_q == WR_LAST)
        begin
          wr_n_d  = `EMB_STROBE_OFF;
          state_d = EMB_WR_HOLD;
        end
        else
        begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      EMB_WR_HOLD:
      begin
        oe_d    = '0;
        cs_n_d  = '1;
        state_d = EMB_IDLE;
      end
      default:
      begin
        state_d = EMB_IDLE;
      end
    endcase
    busy_d = (state_d != EMB_IDLE);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (bus_rst)
    begin
      state_q  <= EMB_IDLE;
      cnt_q    <= '0;
      addr_q   <= '0;
      wdata_q  <= '0;
      oe_q     <= '0;
      rdata_q  <= '0;
      cs_n_q   <= '1;
      rd_n_q   <= `EMB_STROBE_OFF;
      wr_n_q   <= `EMB_STROBE_OFF;
      rvalid_q <= 1'b0;
      busy_q   <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      oe_q     <= oe_d;
      rdata_q  <= rdata_d;
      cs_n_q   <= cs_n_d;
      rd_n_q   <= rd_n_d;
      wr_n_q   <= wr_n_d;
      rvalid_q <= rvalid_d;
      busy_q   <= busy_d;
    end
  end

  assign busy_o          = busy_q;
  assign rd_valid_o      = rvalid_q;
  assign rd_data_o       = rdata_q;
  assign addr_o          = addr_q;
  assign data_o          = wdata_q;
  assign data_oe_o       = oe_q;
  assign rd_n_o          = rd_n_q;
  assign wr_n_o          = wr_n_q;
  assign chip_select_n_o = cs_n_q;

endmodule

// ==== tb/emb_monitor.sv ====
`timescale 1ns/1ps
module emb_monitor
  import emb_pkg::*;
(
  input logic        ref_clk_i,
  input logic        nrst_i,
  input logic        por_n_i,
  input logic        ext_rst_n_i,
  input logic        req_valid_i,
  input logic        req_write_i,
  input logic        busy_o,
  input logic        rd_valid_o,
  input logic [15:0] rd_data_o,
  input logic [15:0] system_integration_control_o,
  input logic [20:0] addr_o,
  input logic [15:0] data_i,
  input logic [15:0] data_oe_o,
  input logic        rd_n_o,
  input logic        wr_n_o,
  input logic [3:0]  chip_select_n_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_take(w);
    req_valid_i && !busy_o && req_write_i == w;
  endsequence
  // Strobe shapes assume the default two-clock strobe length
  sequence s_rd_strobe;
    (!rd_n_o && data_oe_o == '0 && busy_o) [*2];
  endsequence
  sequence s_wr_strobe;
    (!wr_n_o && data_oe_o == '1) [*2];
  endsequence
  a_idle_quiet: assert property (!busy_o |->
    data_oe_o == '0 && chip_select_n_o == '1) else $error("idle bus active");
  a_read_walk: assert property (s_take(1'b0) |=> s_rd_strobe ##1
    (rd_n_o && rd_valid_o && !busy_o)) else $error("bad read cycle");
  a_read_capture: assert property (rd_valid_o |->
    !$past(rd_n_o) && rd_data_o == $past(data_i)) else $error("bad capture");
  a_write_walk: assert property (s_take(1'b1) |=>
    (wr_n_o && data_oe_o == '1) ##1 s_wr_strobe ##1 (wr_n_o && busy_o)
    ##1 !busy_o) else $error("bad write cycle");
  a_addr_hold: assert property (!wr_n_o && !$past(wr_n_o) |->
    $stable(addr_o)) else $error("address moved under strobe");
  a_strobe_excl: assert property (!rd_n_o |->
    wr_n_o && data_oe_o == '0) else $error("strobe overlap");
  a_mode_track: assert property (!por_n_i || !ext_rst_n_i |=>
    system_integration_control_o == {1'b0, $past(data_i[15:13]), 12'h0})
    else $error("mode bits not tracking straps");
  a_mode_hold: assert property (por_n_i && ext_rst_n_i &&
    $past(por_n_i) && $past(ext_rst_n_i) |->
    $stable(system_integration_control_o)) else $error("mode bits changed");
endmodule
bind emb_top emb_monitor u_mon (.*);

// ==== tb/emb_mem_model.sv ====
`timescale 1ns/1ps
// Asynchronous static memory sitting on chip select 0
module emb_mem_model
#(
  parameter time ACC_DLY = 5ns
)
(
  input  logic [20:0] addr_i,
  input  logic [15:0] data_i,
  input  logic        rd_n_i,
  input  logic        wr_n_i,
  input  logic        cs_n_i,
  output logic [15:0] data_o,
  output logic        data_oe_o
);
  logic [15:0] mem [logic [15:0]];
  initial
  begin
    data_o = '0;
    data_oe_o = 1'b0;
  end
  always @(posedge wr_n_i)
    if (!cs_n_i)
      mem[addr_i[15:0]] = data_i;
  always @(rd_n_i, cs_n_i)
    if (!rd_n_i && !cs_n_i)
    begin
      data_oe_o = 1'b1;
      // Unwritten words read as zero rather than unknown
      #ACC_DLY data_o = mem.exists(addr_i[15:0]) ?
                        mem[addr_i[15:0]] : 16'h0;
    end
    else
    begin
      data_oe_o = 1'b0;
      // Released lines must not keep showing the last word
      data_o = ~data_o;
    end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  localparam int A = 21;
  localparam logic [3:0] EN = 4'hb;
  localparam logic [83:0] BASE = {21'h1fff00, 21'h0, 21'h100000, 21'h0};
  // Select 0 decodes all of a[20:16] so the memory never aliases upper space
  localparam logic [83:0] MASK = {21'h1fff00, 21'h0, 21'h100000, 21'h1f0000};
  logic        ref_clk_i = 1'b0, nrst_i = 1'b0, por_n_i = 1'b0;
  logic        ext_rst_n_i = 1'b1, sw_rst_i = 1'b0, req_valid_i = 1'b0;
  logic        watchdog_reset_source_i = 1'b0, req_write_i = 1'b0;
  logic        busy_o, rd_valid_o, rd_n_o, wr_n_o, m_oe;
  logic [20:0] req_addr_i = '0, addr_o;
  logic [15:0] req_wdata_i = '0, rd_data_o, data_o, data_oe_o, m_q, got;
  logic [15:0] system_integration_control_o;
  logic [15:0] exp_mem [logic [15:0]];
  logic [3:0]  chip_select_n_o;
  logic [2:0]  strap = 3'h5;
  wire  [15:0] data_i;
  int          fail_count = 0, checks = 0, cycles = 0, seed = 32'h9e73;
  emb_top dut (.ref_clk_i, .nrst_i, .por_n_i, .ext_rst_n_i, .sw_rst_i,
    .watchdog_reset_source_i, .req_valid_i, .req_write_i, .req_addr_i,
    .req_wdata_i, .cs_enable_i(EN), .cs_base_i(BASE), .cs_mask_i(MASK),
    .busy_o, .rd_valid_o, .rd_data_o, .system_integration_control_o, .addr_o,
    .data_i, .data_o, .data_oe_o, .rd_n_o, .wr_n_o, .chip_select_n_o);
  emb_mem_model #(.ACC_DLY(40ns)) mem_model (.addr_i(addr_o), .data_i,
    .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .cs_n_i(chip_select_n_o[0]),
    .data_o(m_q), .data_oe_o(m_oe));
  // Strap resistors hold the top pins whenever nobody drives them
  assign data_i = (data_oe_o & data_o) |
                  (~data_oe_o & (m_oe ? m_q : {strap, m_q[12:0]}));
  initial
    forever #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      results();
    end
  end
  function automatic logic [3:0] cs_exp(logic [20:0] a);
    for (int n = 0; n < 4; n++)
      cs_exp[n] = !(EN[n] && ((a ^ BASE[n*A+:A]) & MASK[n*A+:A]) == '0);
  endfunction
  task automatic chk(logic [15:0] g, logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk_i) #2;
  endtask
  task automatic access(logic w, logic [20:0] a, logic [15:0] d);
    int n;
    n = 0;
    req_valid_i = 1'b1;
    req_write_i = w;
    req_addr_i = a;
    req_wdata_i = d;
    tick();
    req_valid_i = 1'b0;
    chk(16'(chip_select_n_o), 16'(cs_exp(a)));
    while (busy_o !== 1'b0 && n < 20)
    begin
      tick();
      n++;
    end
    chk(16'(busy_o), 16'h0);
    if (!w)
      chk(16'(rd_valid_o), 16'h1);
    if (a[20:16] == '0 && w)
      exp_mem[a[15:0]] = d;
    else if (a[20:16] == '0 && exp_mem.exists(a[15:0]))
    begin
      got = rd_valid_o === 1'b1 ? rd_data_o : ~exp_mem[a[15:0]];
      chk(got, exp_mem[a[15:0]]);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    logic [20:0] a;
    logic [15:0] d;
    repeat (2) tick();
    nrst_i = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      strap = 3'(i);
      por_n_i = i[0];
      ext_rst_n_i = !i[0];
      tick();
      por_n_i = 1'b1;
      ext_rst_n_i = 1'b1;
      tick();
      chk(system_integration_control_o, {1'b0, strap, 12'h0});
    end
    strap = 3'h2;
    sw_rst_i = 1'b1;
    tick();
    sw_rst_i = 1'b0;
    watchdog_reset_source_i = 1'b1;
    tick();
    watchdog_reset_source_i = 1'b0;
    chk(system_integration_control_o, 16'h7000);
    for (int i = 0; i < 48; i++)
    begin
      a = 21'($random(seed));
      d = 16'($random(seed));
      if (d[1] || i < 8)
        a[20:3] = '0;
      if (i < 8)
        a[2:0] = 3'(i);
      if (i < 2)
        d = {16{i[0]}};
      if (i % 8 == 7)
        a = 21'h1fff00 | 21'(d[7:0]);
      access(i < 8 || d[0], a, d);
    end
    nrst_i = 1'b0;
    repeat (2) tick();
    nrst_i = 1'b1;
    access(1'b0, 21'h1, 16'h0);
    results();
  end
endmodule
